// File: src/dcs_pkg.sv
// shared constants, types and helpers for the burst-of-two memory link
`default_nettype none
package dcs_pkg;

  // =====================================================================
  // bus geometry
  localparam int DQ_MAX = 36;
  localparam int LANE_W = 9;
  localparam int BW_MAX = DQ_MAX / LANE_W;
  localparam int ADDR_W_DEF = 8;

  // =====================================================================
  // clocking and timing
  localparam int REF_HZ = 20_000_000;
  localparam int K_DIV = 4;
  localparam int K_HZ = REF_HZ / K_DIV;
  localparam int K_PHASE_DEG = 180;
  localparam int BYPASS_MAX_HZ = 167_000_000;
  localparam int LOCK_CYCLES_DEF = 1024;
  // divider phase at a clock edge or level, or the phase that precedes a pin update
  localparam logic [1:0] PH_K_RISE = 2'h0;
  localparam logic [1:0] PH_K_HIGH = 2'h1;
  localparam logic [1:0] PH_KN_RISE = 2'h2;
  localparam logic [1:0] PH_CMD_PREV = 2'h2;
  localparam logic [1:0] PH_W1_PREV = 2'h0;

  // =====================================================================
  // controller states
  typedef enum logic [2:0] {
    HS_IDLE,
    HS_WR0,
    HS_WR1,
    HS_WEND,
    HS_RWAIT,
    HS_GAP
  } dcs_hst_e;

  // =====================================================================
  // lines in use for a given data width
  function automatic logic [DQ_MAX-1:0] dcs_dq_mask(input int w);
    dcs_dq_mask = {DQ_MAX{1'b1}} >> (DQ_MAX - w);
  endfunction : dcs_dq_mask

endpackage : dcs_pkg
`default_nettype wire

// File: src/dcs_link_if.sv
// pin-level link between the memory controller and the memory
`default_nettype none
interface dcs_link_if
  import dcs_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF
)
();
  logic k;
  logic k_n;
  logic [ADDR_W-1:0] addr_in;
  logic load_n;
  logic read_write;
  logic [BW_MAX-1:0] byte_write_n;
  logic dll_off_n;
  logic [DQ_MAX-1:0] hdq_out;
  logic [DQ_MAX-1:0] hdq_oe;
  logic [DQ_MAX-1:0] ddq_out;
  logic [DQ_MAX-1:0] ddq_oe;
  wire [DQ_MAX-1:0] shared_data_bus;
  logic echo_timing_pos;
  logic echo_timing_neg;
  logic output_valid_flag;

  // =====================================================================
  // bus resolution
  genvar i;
  generate
    for (i = 0; i < DQ_MAX; i++)
    begin : g_bit
      // an idle line shows the inverse of the host's last bit, so a
      // stale sample stands out
      assign shared_data_bus[i] = hdq_oe[i] ? hdq_out[i] :
                                  (ddq_oe[i] ? ddq_out[i] : ~hdq_out[i]);
    end
  endgenerate

  modport mem_end (
    input k, k_n, addr_in, load_n, read_write, byte_write_n, dll_off_n,
    input shared_data_bus,
    output ddq_out, ddq_oe, echo_timing_pos, echo_timing_neg,
    output output_valid_flag
  );

  modport ctrl_end (
    output k, k_n, addr_in, load_n, read_write, byte_write_n, dll_off_n,
    output hdq_out, hdq_oe,
    input shared_data_bus, echo_timing_pos, echo_timing_neg,
    input output_valid_flag
  );
endinterface : dcs_link_if
`default_nettype wire

// File: src/dcs_ctrl_end.sv
// memory controller end: makes the link clocks and runs one burst at a time
`default_nettype none
module dcs_ctrl_end
  import dcs_pkg::*;
#(
  parameter int DQ_W = DQ_MAX,
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int LOCK_CYCLES = LOCK_CYCLES_DEF
)
(
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic DLL_ENABLE_IN,
  input wire logic REQ_VALID_IN,
  input wire logic REQ_WRITE_IN,
  input wire logic [ADDR_W-1:0] REQ_ADDR_IN,
  input wire logic [2*DQ_W-1:0] REQ_WDATA_IN,
  input wire logic [2*(DQ_W/LANE_W)-1:0] REQ_BYTE_WRITE_N_IN,
  output logic REQ_READY_OUT,
  output logic RD_VALID_OUT,
  output logic [2*DQ_W-1:0] RD_DATA_OUT,
  dcs_link_if.ctrl_end LINK
);

  localparam int NB = DQ_W / LANE_W;
  localparam int LIM = LOCK_CYCLES * K_DIV;
  localparam int LCW = $clog2(LIM + 1);

  // =====================================================================
  // state
  typedef struct packed {
    logic [1:0] ph;
    logic k;
    logic kn;
    logic dll_off_n;
    logic [LCW-1:0] lock_cnt;
    dcs_hst_e st;
    logic load_n;
    logic rw;
    logic [ADDR_W-1:0] addr;
    logic [NB-1:0] bw;
    logic [DQ_W-1:0] dq;
    logic oe;
    logic [2*DQ_W-1:0] wd;
    logic [2*NB-1:0] wb;
    logic v1;
    logic v2;
    logic e1;
    logic e2;
    logic [DQ_W-1:0] d1;
    logic [DQ_W-1:0] d2;
    logic eprev;
    logic [DQ_W-1:0] rlo;
    logic [2*DQ_W-1:0] rdat;
    logic rvld;
    logic rst_hold;
  } dcs_hctl_s;

  dcs_hctl_s hq;
  dcs_hctl_s hd;
  logic at_cmd;
  logic at_w1;
  logic take;
  logic lock_ok;

  assign at_cmd = hq.ph == PH_CMD_PREV;
  assign at_w1 = hq.ph == PH_W1_PREV;
  assign take = hq.v2 && (hq.e2 != hq.eprev);
  // bypass needs no wait; this divider keeps well under the bypass ceiling
  assign lock_ok = !hq.dll_off_n || (hq.lock_cnt == LCW'(LIM));

  // =====================================================================
  // next state
  always_comb
  begin
    hd = hq;
    hd.rst_hold = 1'b0;
    // free running, so the memory sees clocks while held in reset
    case (hq.ph)
      2'h0: hd.ph = 2'h1;
      2'h1: hd.ph = 2'h2;
      2'h2: hd.ph = 2'h3;
      default: hd.ph = 2'h0;
    endcase
    hd.k = (hd.ph == PH_K_RISE) || (hd.ph == PH_K_HIGH);
    hd.kn = ~hd.k;
    hd.d1 = LINK.shared_data_bus[DQ_W-1:0];
    hd.d2 = hq.d1;
    hd.v1 = LINK.output_valid_flag;
    hd.v2 = hq.v1;
    hd.e1 = LINK.echo_timing_pos;
    hd.e2 = hq.e1;
    hd.eprev = hq.e2;
    hd.rvld = 1'b0;
    // low echo marks the first word, high echo the second
    if (take && !hq.e2)
      hd.rlo = hq.d2;
    if (take && hq.e2)
    begin
      hd.rdat = {hq.d2, hq.rlo};
      hd.rvld = 1'b1;
    end
    hd.dll_off_n = DLL_ENABLE_IN;
    if (!hq.dll_off_n)
      hd.lock_cnt = '0;
    else if (hq.lock_cnt != LCW'(LIM))
      hd.lock_cnt = hq.lock_cnt + LCW'(1);
    if (at_cmd)
      hd.load_n = 1'b1;
    case (hq.st)
      HS_IDLE:
        if (at_cmd && REQ_VALID_IN && lock_ok)
        begin
          hd.load_n = 1'b0;
          hd.rw = ~REQ_WRITE_IN;
          hd.addr = REQ_ADDR_IN;
          hd.wd = REQ_WDATA_IN;
          hd.wb = REQ_BYTE_WRITE_N_IN;
          hd.st = REQ_WRITE_IN ? HS_WR0 : HS_RWAIT;
        end
      HS_WR0:
        if (at_cmd)
        begin
          hd.dq = hq.wd[DQ_W-1:0];
          hd.bw = hq.wb[NB-1:0];
          hd.oe = 1'b1;
          hd.st = HS_WR1;
        end
      HS_WR1:
        if (at_w1)
        begin
          hd.dq = hq.wd[2*DQ_W-1:DQ_W];
          hd.bw = hq.wb[2*NB-1:NB];
          hd.st = HS_WEND;
        end
      HS_WEND:
        if (at_cmd)
        begin
          hd.oe = 1'b0;
          hd.bw = '1;
          hd.st = HS_IDLE;
        end
      HS_RWAIT:
        if (take && hq.e2)
          hd.st = HS_GAP;
      HS_GAP:
        if (at_cmd)
          hd.st = HS_IDLE;
      default: hd.st = HS_IDLE;
    endcase
    if (!RSTN_IN)
    begin
      hd = '0;
      // restart the divider on entry, then keep it running so the
      // memory's reset sync still sees clock edges
      if (hq.rst_hold)
        hd.ph = hq.ph + 2'h1;
      hd.rst_hold = 1'b1;
      hd.k = (hd.ph == PH_K_RISE) || (hd.ph == PH_K_HIGH);
      hd.kn = ~hd.k;
      hd.load_n = 1'b1;
      hd.bw = '1;
      hd.st = HS_IDLE;
    end
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    hq <= hd;
  end

  // =====================================================================
  // outputs
  assign REQ_READY_OUT = RSTN_IN && (hq.st == HS_IDLE) && at_cmd && lock_ok;
  assign RD_VALID_OUT = hq.rvld;
  assign RD_DATA_OUT = hq.rdat;
  assign LINK.k = hq.k;
  assign LINK.k_n = hq.kn;
  assign LINK.addr_in = hq.addr;
  assign LINK.load_n = hq.load_n;
  assign LINK.read_write = hq.rw;
  assign LINK.byte_write_n = BW_MAX'({{BW_MAX{1'b1}}, hq.bw});
  assign LINK.dll_off_n = hq.dll_off_n;
  assign LINK.hdq_out = DQ_MAX'(hq.dq);
  assign LINK.hdq_oe = hq.oe ? dcs_dq_mask(DQ_W) : '0;

endmodule : dcs_ctrl_end
`default_nettype wire

// File: src/dcs_mem_end.sv
// memory end: burst-of-two double-data-rate common-i/o storage on the link
// =======================================================================
`default_nettype none
module dcs_mem_end
  import dcs_pkg::*;
#(
  parameter int DQ_W = DQ_MAX,
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int LOCK_CYCLES = LOCK_CYCLES_DEF
)
(
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  dcs_link_if.mem_end LINK,
  output logic DLL_LOCKED_OUT
);

  localparam int NB = DQ_W / LANE_W;
  localparam int LCW = $clog2(LOCK_CYCLES + 1);

  // =====================================================================
  // state of the true-clock side
  typedef struct packed {
    logic rst1;
    logic rst2;
    logic off1;
    logic off2;
    logic [LCW-1:0] lock_cnt;
    logic locked;
    logic tog;
    logic rd_a;
    logic rd_b;
    logic rd_c;
    logic [ADDR_W-1:0] ra;
    logic [DQ_W-1:0] rb0;
    logic [DQ_W-1:0] rb1;
    logic [DQ_W-1:0] rc0;
    logic [DQ_W-1:0] rc1;
    logic wr_a;
    logic wr_b;
    logic [ADDR_W-1:0] wa;
    logic [ADDR_W-1:0] wab;
    logic [DQ_W-1:0] dk;
    logic vk;
  } dcs_kst_s;

  // =====================================================================
  // state of the complementary-clock side
  typedef struct packed {
    logic tog;
    logic [DQ_W-1:0] dkn;
    logic vkn;
    logic lpend;
    logic [DQ_W-1:0] w1;
    logic [DQ_W-1:0] ww1;
    logic [NB-1:0] wbw1;
    logic wv;
  } dcs_nst_s;

  // =====================================================================
  // state of the reference-clock side
  typedef struct packed {
    logic lk1;
    logic lk2;
  } dcs_lsy_s;

  dcs_kst_s kq;
  dcs_kst_s kd;
  dcs_nst_s nq;
  dcs_nst_s nd;
  dcs_lsy_s lq;
  dcs_lsy_s ld;
  logic [DQ_W-1:0] mem [2**(ADDR_W+1)];
  logic bypass;
  logic ph;
  logic drv;

  assign bypass = ~kq.off2;

  // =====================================================================
  // true-clock side: commands, read pipeline, loop lock
  always_comb
  begin
    kd = kq;
    if (!kq.rst2)
    begin
      kd = '0;
    end
    else
    begin
      kd.tog = ~kq.tog;
      if (!kq.off2)
      begin
        kd.lock_cnt = '0;
        kd.locked = 1'b0;
      end
      else if (kq.lock_cnt == LCW'(LOCK_CYCLES))
        kd.locked = 1'b1;
      else
        kd.lock_cnt = kq.lock_cnt + LCW'(1);
      kd.rd_a = 1'b0;
      kd.wr_a = 1'b0;
      // a deselected cycle leaves the held addresses alone
      if (!LINK.load_n)
      begin
        if (LINK.read_write)
        begin
          kd.rd_a = 1'b1;
          kd.ra = LINK.addr_in;
        end
        else
        begin
          kd.wr_a = 1'b1;
          kd.wa = LINK.addr_in;
        end
      end
      kd.rd_b = kq.rd_a;
      if (kq.rd_a)
      begin
        kd.rb0 = mem[{kq.ra, 1'b0}];
        kd.rb1 = mem[{kq.ra, 1'b1}];
      end
      // extra stage gives the 2.5 cycle latency with the loop running
      kd.rd_c = kq.rd_b;
      if (kq.rd_b)
      begin
        kd.rc0 = kq.rb0;
        kd.rc1 = kq.rb1;
      end
      kd.wr_b = kq.wr_a;
      if (kq.wr_a)
        kd.wab = kq.wa;
      kd.vk = nq.lpend;
      if (nq.lpend)
        kd.dk = nq.w1;
    end
    kd.rst1 = RSTN_IN;
    kd.rst2 = kq.rst1;
    kd.off1 = LINK.dll_off_n;
    kd.off2 = kq.off1;
  end

  always_ff @(posedge LINK.k)
  begin
    kq <= kd;
  end

  // =====================================================================
  // storage: first word on the true edge, second a cycle later
  always_ff @(posedge LINK.k)
  begin
    for (int l = 0; l < NB; l++)
    begin
      if (kq.rst2 && kq.wr_a && !LINK.byte_write_n[l])
        mem[{kq.wa, 1'b0}][l*LANE_W +: LANE_W] <=
          LINK.shared_data_bus[l*LANE_W +: LANE_W];
      if (kq.rst2 && nq.wv && !nq.wbw1[l])
        mem[{kq.wab, 1'b1}][l*LANE_W +: LANE_W] <=
          nq.ww1[l*LANE_W +: LANE_W];
    end
  end

  // =====================================================================
  // complementary-clock side: first read word out, second write word in
  always_comb
  begin
    nd = nq;
    if (!kq.rst2)
    begin
      nd = '0;
    end
    else
    begin
      // follow the true side, so the echo level is right whichever
      // clock edge comes first after reset
      nd.tog = kq.tog;
      nd.vkn = bypass ? kq.rd_b : kq.rd_c;
      nd.lpend = nd.vkn;
      if (nd.vkn)
      begin
        nd.dkn = bypass ? kq.rb0 : kq.rc0;
        nd.w1 = bypass ? kq.rb1 : kq.rc1;
      end
      nd.wv = kq.wr_b;
      if (kq.wr_b)
      begin
        nd.ww1 = LINK.shared_data_bus[DQ_W-1:0];
        nd.wbw1 = LINK.byte_write_n[NB-1:0];
      end
    end
  end

  always_ff @(posedge LINK.k_n)
  begin
    nq <= nd;
  end

  // =====================================================================
  // pins: high phase follows a true edge, low phase a complementary one
  assign ph = kq.tog ^ nq.tog;
  assign drv = ph ? kq.vk : nq.vkn;
  assign LINK.echo_timing_pos = ph;
  assign LINK.echo_timing_neg = ~ph;
  assign LINK.output_valid_flag = drv;
  assign LINK.ddq_out = DQ_MAX'(ph ? kq.dk : nq.dkn);
  assign LINK.ddq_oe = drv ? dcs_dq_mask(DQ_W) : '0;

  // =====================================================================
  // lock status into the reference domain
  always_comb
  begin
    ld.lk1 = kq.locked;
    ld.lk2 = lq.lk1;
    if (!RSTN_IN)
      ld = '0;
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    lq <= ld;
  end

  assign DLL_LOCKED_OUT = lq.lk2;

endmodule : dcs_mem_end
`default_nettype wire

// File: bench/dcs_link_checker.sv
// timing checks on the pin link between controller and memory
`default_nettype none
module dcs_link_checker
  import dcs_pkg::*;
(
  input wire logic rst_n,
  input wire logic k,
  input wire logic k_n,
  input wire logic load_n,
  input wire logic read_write,
  input wire logic dll_off_n,
  input wire logic [DQ_MAX-1:0] hdq_oe,
  input wire logic [DQ_MAX-1:0] ddq_oe,
  input wire logic echo_timing_pos,
  input wire logic echo_timing_neg,
  input wire logic output_valid_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // settle count: the memory reset crosses a two-flop sync first
  logic [2:0] up_q;
  logic [2:0] up_d;
  always_comb up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
  always_ff @(posedge k)
    up_q <= rst_n ? up_d : 3'h0;

  default clocking cb @(posedge k);
  endclocking
  default disable iff (!rst_n);

  // ====================
  // assertions
  a_echo_pair: assert property (up_q == 3'h7 |->
    echo_timing_neg != echo_timing_pos)
    else $error("echo pair not complementary");
  a_echo_low_k: assert property (up_q == 3'h7 |->
    !echo_timing_pos)
    else $error("echo high at true clock rise");
  a_echo_high_kn: assert property (@(posedge k_n)
    disable iff (!rst_n) up_q == 3'h7 |-> echo_timing_pos)
    else $error("echo low at complementary rise");
  a_clk_phase: assert property (k_n)
    else $error("clock pair not opposite");
  a_valid_drive: assert property (up_q == 3'h7 |->
    output_valid_flag == (|ddq_oe))
    else $error("valid flag differs from bus drive");
  a_no_fight: assert property (!(|(hdq_oe & ddq_oe)))
    else $error("both ends drive the bus");
  a_rd_lat_dll: assert property (
    !load_n && read_write && dll_off_n && $past(dll_off_n, 4)
    |-> ##1 !output_valid_flag [*2] ##1 output_valid_flag
    ##1 !output_valid_flag)
    else $error("read latency wrong with loop on");
  a_rd_lat_byp: assert property (
    !load_n && read_write && !dll_off_n && !$past(dll_off_n, 4)
    |-> ##1 !output_valid_flag ##1 output_valid_flag
    ##1 !output_valid_flag)
    else $error("read latency wrong in bypass");
  a_wr_data: assert property (!load_n && !read_write |->
    ##1 hdq_oe[0] ##1 !hdq_oe[0])
    else $error("write data not driven for two edges");
  a_load_pulse: assert property (!load_n |=> load_n)
    else $error("load held low twice");

  c_read_dll: cover property (!load_n && read_write && dll_off_n);
  c_read_byp: cover property (!load_n && read_write && !dll_off_n);
  c_write: cover property (!load_n && !read_write);
endmodule : dcs_link_checker
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench: controller and memory ends on one link
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("mismatch %s exp %h got %h", nm, e, g); \
    end \
  end
module tb_top
  import dcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AW = 4;
  localparam int NB = DQ_MAX / LANE_W;
  localparam int LK = 8;
  logic REF_CLK_IN = 1'h0;
  logic RSTN_IN = 1'h0;
  logic DLL_ENABLE_IN = 1'h1;
  logic REQ_VALID_IN = 1'h0;
  logic REQ_WRITE_IN = 1'h0;
  logic [AW-1:0] REQ_ADDR_IN = '0;
  logic [2*DQ_MAX-1:0] REQ_WDATA_IN = '0;
  logic [2*NB-1:0] REQ_BYTE_WRITE_N_IN = '1;
  logic REQ_READY_OUT;
  logic RD_VALID_OUT;
  logic [2*DQ_MAX-1:0] RD_DATA_OUT;
  logic DLL_LOCKED_OUT;
  logic [DQ_MAX-1:0] mem [int];
  logic [31:0] rs = 32'h658A;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int ncmd = 0;
  int nops = 0;
  int wait_n = 0;

  always #25 REF_CLK_IN = ~REF_CLK_IN;

  dcs_link_if #(.ADDR_W(AW)) link ();
  dcs_ctrl_end #(.DQ_W(DQ_MAX), .ADDR_W(AW), .LOCK_CYCLES(LK))
    dcs_ctrl_end_inst (.REF_CLK_IN, .RSTN_IN, .DLL_ENABLE_IN,
    .REQ_VALID_IN, .REQ_WRITE_IN, .REQ_ADDR_IN, .REQ_WDATA_IN,
    .REQ_BYTE_WRITE_N_IN, .REQ_READY_OUT, .RD_VALID_OUT,
    .RD_DATA_OUT, .LINK(link.ctrl_end));
  dcs_mem_end #(.DQ_W(DQ_MAX), .ADDR_W(AW), .LOCK_CYCLES(LK))
    dcs_mem_end_inst (.REF_CLK_IN, .RSTN_IN,
    .LINK(link.mem_end), .DLL_LOCKED_OUT);
  dcs_link_checker chk (.rst_n(RSTN_IN), .k(link.k), .k_n(link.k_n),
    .load_n(link.load_n), .read_write(link.read_write),
    .dll_off_n(link.dll_off_n), .hdq_oe(link.hdq_oe),
    .ddq_oe(link.ddq_oe), .echo_timing_pos(link.echo_timing_pos),
    .echo_timing_neg(link.echo_timing_neg),
    .output_valid_flag(link.output_valid_flag));

  // ====================
  // run limit and wire-level command count
  always @(posedge REF_CLK_IN)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      final_report();
    end
  end
  always @(posedge link.k)
    if (RSTN_IN && !link.load_n)
      ncmd++;

  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : xs

  // ====================
  // one request; the model tracks writes and judges reads
  task automatic op(input logic w, input logic [AW-1:0] a,
    input logic [2*DQ_MAX-1:0] d, input logic [2*NB-1:0] bw);
    int n;
    logic e;
    REQ_VALID_IN = 1'h1;
    REQ_WRITE_IN = w;
    REQ_ADDR_IN = a;
    REQ_WDATA_IN = d;
    REQ_BYTE_WRITE_N_IN = bw;
    n = 0;
    #1;
    while (REQ_READY_OUT !== 1'h1 && n < 4000)
    begin
      @(negedge REF_CLK_IN);
      #1;
      n++;
    end
    wait_n = n;
    @(negedge REF_CLK_IN);
    REQ_VALID_IN = 1'h0;
    nops++;
    if (w)
      for (int l = 0; l < 2*NB; l++)
        if (!bw[l])
          mem[2*a+l/NB][(l%NB)*LANE_W +: LANE_W] =
            d[l*LANE_W +: LANE_W];
    if (!w)
    begin
      n = 0;
      while (RD_VALID_OUT !== 1'h1 && n < 100)
      begin
        @(negedge REF_CLK_IN);
        n++;
      end
      `CHK("rd_data", {mem[2*a+1], mem[2*a]}, RD_DATA_OUT)
    end
    repeat (20) @(negedge REF_CLK_IN);
    `CHK("bus idle", {2*DQ_MAX{1'h0}}, {link.hdq_oe, link.ddq_oe})
    e = link.echo_timing_pos;
    repeat (2) @(negedge REF_CLK_IN);
    `CHK("echo toggle", ~e, link.echo_timing_pos)
  endtask : op

  task automatic rnd_ops(input int cnt);
    logic [31:0] r;
    logic [95:0] dv;
    for (int i = 0; i < cnt; i++)
    begin
      r = xs();
      dv = {xs(), xs(), xs()};
      op(r[31], r[AW-1:0], dv[2*DQ_MAX-1:0], r[15:8]);
    end
  endtask : rnd_ops

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  // ====================
  // main sequence; the lock wait covers the memory's two-flop reset sync
  initial
  begin
    logic [95:0] dv;
    repeat (5) @(negedge REF_CLK_IN);
    RSTN_IN = 1'h1;
    for (int a = 0; a < 2**AW; a++)
    begin
      dv = {xs(), xs(), xs()};
      op(1'h1, a[AW-1:0], dv[2*DQ_MAX-1:0], '0);
      if (a == 0)
        `CHK("lock wait", 1'h1, wait_n >= 4*LK)
    end
    `CHK("locked", 1'h1, DLL_LOCKED_OUT)
    $display("test fill done");
    rnd_ops(30);
    $display("test loop on done");
    DLL_ENABLE_IN = 1'h0;
    repeat (40) @(negedge REF_CLK_IN);
    `CHK("unlocked", 1'h0, DLL_LOCKED_OUT)
    rnd_ops(20);
    $display("test bypass done");
    DLL_ENABLE_IN = 1'h1;
    op(1'h0, '0, '0, '1);
    `CHK("relock wait", 1'h1, wait_n >= 4*LK)
    rnd_ops(10);
    $display("test relock done");
    RSTN_IN = 1'h0;
    repeat (16) @(negedge REF_CLK_IN);
    RSTN_IN = 1'h1;
    for (int a = 0; a < 4; a++)
      op(1'h0, a[AW-1:0], '0, '1);
    $display("test second reset done");
    `CHK("cmd count", nops, ncmd)
    final_report();
  end
endmodule : tb_top
`default_nettype wire
